// ==== design/sie_iic_chan.sv ====
// Simplified two-wire master channel with error recovery and start/stop control.
// Assumes host software drives the control ports and a slave sits on the bus.
// Summary of operation
// - Serial clock has equal low and high, except the longer start and restart highs
// - Reading data clears buffer-full flag
// - Status shows overflow or missing acknowledge
// - Writing ones clears matching error flags
// - Stop bit clears enable status, halts
// - Missing acknowledge is an error
// - Start bit without stop sets enable status, resumes
// - Rate is running clock over 2(div+1)
// - Running clock from one of two prescalers
`timescale 1ns/1ps
module sie_iic_chan
   import sie_pkg::*;
(
   input  wire logic             I_REF_CLK,
   input  wire logic             I_RST_N,
   input  wire logic [PRS_W-1:0] I_PRS0,
   input  wire logic [PRS_W-1:0] I_PRS1,
   input  wire logic             I_PRS_CHOICE,
   input  wire logic             I_START,
   input  wire logic             I_STOP,
   input  wire logic [15:0]      I_DATA_WR,
   input  wire logic             I_DATA_WR_STB,
   input  wire logic             I_DATA_RD_STB,
   input  wire logic             I_READ_MODE,
   input  wire logic             I_SEND_STOP,
   input  wire logic [ERR_W-1:0] I_FLAG_CLR,
   input  wire logic             I_FLAG_CLR_STB,
   input  wire logic             I_SDA_IN,
   output logic                  O_SCL,
   output logic                  O_SDA_OUT,
   output logic                  O_SDA_OE_N,
   output logic                  O_ENABLE,
   output logic                  O_BUSY,
   output logic                  O_BUFFER_FULL,
   output logic [ERR_W-1:0]      O_ERR_STATUS,
   output logic [7:0]            O_RX_DATA
);
   // ==========================================================================
   // Running clock
   logic tick0;
   logic tick1;
   logic mck_tick;

   sie_prescaler u_prs0 (.i_clk(I_REF_CLK), .i_rst_n(I_RST_N), .i_sel(I_PRS0),
                         .o_tick(tick0));
   sie_prescaler u_prs1 (.i_clk(I_REF_CLK), .i_rst_n(I_RST_N), .i_sel(I_PRS1),
                         .o_tick(tick1));
   assign mck_tick = I_PRS_CHOICE ? tick1 : tick0;

   // ==========================================================================
   // SDA input sync: three stages, change accepted when last two agree
   logic sda_s1_ff, sda_s2_ff, sda_s3_ff, sda_ff;
   logic nxt_sda;
   always_comb begin
      nxt_sda = (sda_s2_ff == sda_s3_ff) ? sda_s3_ff : sda_ff;
   end
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
         sda_ff    <= 1'b1;
      end else begin
         sda_s1_ff <= I_SDA_IN;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
         sda_ff    <= nxt_sda;
      end
   end

   // ==========================================================================
   // Channel state
   sie_state_t       state_ff,  nxt_state;
   logic             en_ff,     nxt_en;
   logic [DIV_W-1:0] div_ff,    nxt_div;
   logic [DIV_W-1:0] hcnt_ff,   nxt_hcnt;
   logic             phase_ff,  nxt_phase;
   logic             scl_ff,    nxt_scl;
   logic             sda_o_ff,  nxt_sda_o;
   logic             oe_n_ff,   nxt_oe_n;
   logic [3:0]       bit_ff,    nxt_bit;
   logic [7:0]       shift_ff,  nxt_shift;
   logic [7:0]       rx_ff,     nxt_rx;
   logic             bff_ff,    nxt_bff;
   logic [ERR_W-1:0] err_ff,    nxt_err;
   logic             rd_ff,     nxt_rd;
   logic             stop_ff,   nxt_stopq;
   logic             busy_ff,   nxt_busy;
   logic             half_end;
   logic             ovf_ev, nack_ev;

   // Half period lasts div+1 running-clock ticks, low and high alike
   assign half_end = mck_tick && (hcnt_ff == div_ff);

   always_comb begin
      nxt_state = state_ff;
      nxt_en    = en_ff;
      nxt_div   = div_ff;
      nxt_hcnt  = hcnt_ff;
      nxt_phase = phase_ff;
      nxt_scl   = scl_ff;
      nxt_sda_o = sda_o_ff;
      nxt_oe_n  = oe_n_ff;
      nxt_bit   = bit_ff;
      nxt_shift = shift_ff;
      nxt_rx    = rx_ff;
      nxt_bff   = bff_ff;
      nxt_rd    = rd_ff;
      nxt_stopq = stop_ff;
      ovf_ev    = 1'b0;
      nack_ev   = 1'b0;

      if (I_START) begin
         nxt_en = 1'b1;
      end
      if (I_STOP) begin
         nxt_en    = 1'b0;
         nxt_state = SIE_IDLE;
         nxt_scl   = 1'b1;
         nxt_oe_n  = 1'b1;
      end

      if (mck_tick && state_ff != SIE_IDLE) begin
         nxt_hcnt = half_end ? 7'h00 : 7'(hcnt_ff + 7'h01);
      end

      if (I_DATA_RD_STB) begin
         nxt_bff = 1'b0;
      end

      if (en_ff && !I_STOP) begin
         case (state_ff)
            SIE_IDLE: begin
               if (I_DATA_WR_STB && I_DATA_WR[DIV_MSB:DIV_LSB] != 7'h00) begin
                  nxt_div   = I_DATA_WR[DIV_MSB:DIV_LSB];
                  nxt_shift = I_DATA_WR[7:0];
                  nxt_rd    = I_READ_MODE;
                  nxt_stopq = I_SEND_STOP;
                  nxt_bit   = BITCNT_RST;
                  nxt_hcnt  = 7'h00;
                  nxt_phase = 1'b0;
                  nxt_state = SIE_START;
               end
            end
            SIE_START: begin
               // Bus kept low after a byte without stop: raise SCL first for a restart
               if (half_end) begin
                  if (!scl_ff) begin
                     nxt_scl   = 1'b1;
                  end else if (!phase_ff) begin
                     nxt_sda_o = 1'b0;
                     nxt_oe_n  = 1'b0;
                     nxt_phase = 1'b1;
                  end else begin
                     // First bit set up while SCL is low, never on its rising edge
                     nxt_scl   = 1'b0;
                     nxt_phase = 1'b0;
                     nxt_sda_o = rd_ff ? 1'b1 : shift_ff[7];
                     nxt_oe_n  = rd_ff;
                     nxt_state = SIE_BIT;
                  end
               end
            end
            SIE_BIT: begin
               if (half_end) begin
                  if (!phase_ff) begin
                     nxt_scl   = 1'b1;
                     nxt_phase = 1'b1;
                  end else begin
                     nxt_scl   = 1'b0;
                     nxt_phase = 1'b0;
                     nxt_shift = {shift_ff[6:0], sda_ff};
                     nxt_sda_o = shift_ff[6];
                     nxt_bit   = 4'(bit_ff + 4'h1);
                     if (bit_ff == 4'h7) begin
                        nxt_state = SIE_ACK;
                        nxt_sda_o = 1'b0;
                        nxt_oe_n  = !rd_ff;
                     end
                  end
               end
            end
            SIE_ACK: begin
               if (half_end) begin
                  if (!phase_ff) begin
                     nxt_scl   = 1'b1;
                     nxt_phase = 1'b1;
                  end else begin
                     nxt_scl   = 1'b0;
                     nxt_phase = 1'b0;
                     // SDA low ahead of a stop, released when the bus is kept for a restart
                     nxt_oe_n  = !stop_ff;
                     nxt_sda_o = !stop_ff;
                     nxt_state = stop_ff ? SIE_STOP : SIE_IDLE;
                     if (rd_ff) begin
                        nxt_rx  = shift_ff;
                        nxt_bff = 1'b1;
                        ovf_ev  = bff_ff && !I_DATA_RD_STB;
                     end else if (sda_ff) begin
                        nack_ev = 1'b1;
                     end
                  end
               end
            end
            SIE_STOP: begin
               if (half_end) begin
                  if (!phase_ff) begin
                     nxt_scl   = 1'b1;
                     nxt_phase = 1'b1;
                  end else begin
                     nxt_oe_n  = 1'b1;
                     nxt_sda_o = 1'b1;
                     nxt_phase = 1'b0;
                     nxt_state = SIE_IDLE;
                  end
               end
            end
            default: nxt_state = SIE_IDLE;
         endcase
      end

      // Set wins over clear so a coincident error is never lost
      nxt_err = err_ff;
      if (I_FLAG_CLR_STB) begin
         nxt_err = err_ff & ~I_FLAG_CLR;
      end
      if (ovf_ev) begin
         nxt_err[ERR_OVF_BIT] = 1'b1;
      end
      if (nack_ev) begin
         nxt_err[ERR_NACK_BIT] = 1'b1;
      end
      nxt_busy = (nxt_state != SIE_IDLE);
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         state_ff <= SIE_IDLE;
         en_ff    <= 1'b0;
         div_ff   <= 7'h01;
         hcnt_ff  <= 7'h00;
         phase_ff <= 1'b0;
         scl_ff   <= 1'b1;
         sda_o_ff <= 1'b1;
         oe_n_ff  <= 1'b1;
         bit_ff   <= BITCNT_RST;
         shift_ff <= DATA_RST;
         rx_ff    <= DATA_RST;
         bff_ff   <= 1'b0;
         err_ff   <= 2'h0;
         rd_ff    <= 1'b0;
         stop_ff  <= 1'b0;
         busy_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         en_ff    <= nxt_en;
         div_ff   <= nxt_div;
         hcnt_ff  <= nxt_hcnt;
         phase_ff <= nxt_phase;
         scl_ff   <= nxt_scl;
         sda_o_ff <= nxt_sda_o;
         oe_n_ff  <= nxt_oe_n;
         bit_ff   <= nxt_bit;
         shift_ff <= nxt_shift;
         rx_ff    <= nxt_rx;
         bff_ff   <= nxt_bff;
         err_ff   <= nxt_err;
         rd_ff    <= nxt_rd;
         stop_ff  <= nxt_stopq;
         busy_ff  <= nxt_busy;
      end
   end

   assign O_SCL         = scl_ff;
   assign O_SDA_OUT     = sda_o_ff;
   assign O_SDA_OE_N    = oe_n_ff;
   assign O_ENABLE      = en_ff;
   assign O_BUSY        = busy_ff;
   assign O_BUFFER_FULL = bff_ff;
   assign O_ERR_STATUS  = err_ff;
   assign O_RX_DATA     = rx_ff;
endmodule : sie_iic_chan

// ==== design/sie_pkg.sv ====
// Package for the simplified two-wire master channel: field layout, reset values,
// state encoding. Assumes a single clock domain and plain-port control.
package sie_pkg;

   // ==========================================================================
   // Field layout
   localparam int         NUM_CH        = 4;
   localparam int         DIV_MSB       = 15;
   localparam int         DIV_LSB       = 9;
   localparam int         DIV_W         = 7;
   localparam int         PRS_W         = 4;
   localparam int         ERR_W         = 2;
   localparam int         ERR_OVF_BIT   = 0;
   localparam int         ERR_NACK_BIT  = 1;
   localparam int         STOP_ALL_W    = 16;
   localparam logic [15:0] STOP_ALL     = 16'h000F;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] DATA_RST      = 8'h00;
   localparam logic [7:0] SCNT_RST      = 8'h00;
   localparam logic [3:0] BITCNT_RST    = 4'h0;

   // ==========================================================================
   // States
   typedef enum logic [2:0] {
      SIE_IDLE  = 3'b000,
      SIE_START = 3'b001,
      SIE_BIT   = 3'b011,
      SIE_ACK   = 3'b010,
      SIE_STOP  = 3'b110
   } sie_state_t;

endpackage : sie_pkg

// ==== design/sie_prescaler.sv ====
// Prescaler, one instance per source in each channel: free-running power-of-two divider yielding one-cycle ticks.
// Assumes a synchronous active-low reset on the system clock.
`timescale 1ns/1ps
module sie_prescaler
   import sie_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [PRS_W-1:0] i_sel,
   output logic                  o_tick
);
   logic [11:0] cnt_ff;
   logic [11:0] nxt_cnt;
   logic        tick_ff;
   logic        nxt_tick;

   always_comb begin
      logic [11:0] mask;
      mask     = 12'h000;
      nxt_cnt  = cnt_ff + 12'h001;
      if (i_sel > 4'hB) begin
         mask = 12'hFFF;
      end else begin
         mask = 12'(( 13'h0001 << i_sel ) - 13'h0001);
      end
      nxt_tick = (cnt_ff & mask) == mask;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_ff  <= 12'h000;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign o_tick = tick_ff;
endmodule : sie_prescaler

// ==== bench/sie_iic_chan_asserts.sv ====
// Port checker for the two-wire channel.
// Assumes binding to sie_iic_chan, one clock domain.
`timescale 1ns/1ps
module sie_iic_chan_asserts
   import sie_pkg::*;
(
   input wire logic             I_REF_CLK,
   input wire logic             I_RST_N,
   input wire logic [PRS_W-1:0] I_PRS0,
   input wire logic [PRS_W-1:0] I_PRS1,
   input wire logic             I_PRS_CHOICE,
   input wire logic             I_START,
   input wire logic             I_STOP,
   input wire logic [15:0]      I_DATA_WR,
   input wire logic             I_DATA_WR_STB,
   input wire logic             I_DATA_RD_STB,
   input wire logic [ERR_W-1:0] I_FLAG_CLR,
   input wire logic             I_FLAG_CLR_STB,
   input wire logic             O_SCL,
   input wire logic             O_SDA_OE_N,
   input wire logic             O_ENABLE,
   input wire logic             O_BUSY,
   input wire logic             O_BUFFER_FULL,
   input wire logic [ERR_W-1:0] O_ERR_STATUS
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   // ======
   // Half-period counter
   logic [15:0]      cnt_ff, nxt_cnt, half;
   logic [DIV_W-1:0] div_ff, nxt_div;
   logic             seen_ff, nxt_seen, scl_ff;
   assign half = ({9'h000, div_ff} + 16'h0001) << (I_PRS_CHOICE ? I_PRS1 : I_PRS0);
   always_comb begin
      nxt_div  = div_ff;
      if (I_DATA_WR_STB && O_ENABLE && !O_BUSY && !I_STOP &&
          I_DATA_WR[DIV_MSB:DIV_LSB] != 7'h00) begin
         nxt_div = I_DATA_WR[DIV_MSB:DIV_LSB];
      end
      nxt_cnt  = (O_SCL != scl_ff) ? 16'h0001 : cnt_ff + 16'h0001;
      // Measuring starts at the first SCL fall; start and restart highs run longer
      nxt_seen = O_BUSY && (seen_ff || (scl_ff && !O_SCL));
   end
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         div_ff  <= 7'h01;
         cnt_ff  <= 16'h0000;
         seen_ff <= 1'b0;
         scl_ff  <= 1'b1;
      end else begin
         div_ff  <= nxt_div;
         cnt_ff  <= nxt_cnt;
         seen_ff <= nxt_seen;
         scl_ff  <= O_SCL;
      end
   end
   // ======
   // Assertions
   a_start_sets_enable: assert property (
      I_START && !I_STOP |=> O_ENABLE)
      else $error("enable not set after start");
   a_stop_halts_chan: assert property (
      I_STOP |=> !O_ENABLE && !O_BUSY && O_SCL && O_SDA_OE_N)
      else $error("channel not halted after stop");
   a_read_clears_full: assert property (
      I_DATA_RD_STB && !O_BUSY |=> !O_BUFFER_FULL)
      else $error("buffer full kept after read");
   a_ones_clear_flags: assert property (
      I_FLAG_CLR_STB && !O_BUSY |=> (O_ERR_STATUS & $past(I_FLAG_CLR)) == 2'b00)
      else $error("error flag not cleared");
   a_zeros_keep_flags: assert property (
      I_FLAG_CLR_STB |=>
         ($past(O_ERR_STATUS) & ~$past(I_FLAG_CLR) & ~O_ERR_STATUS) == 2'b00)
      else $error("error flag lost on zero bit");
   a_errors_stay_set: assert property (
      !I_FLAG_CLR_STB |=> ($past(O_ERR_STATUS) & ~O_ERR_STATUS) == 2'b00)
      else $error("error flag dropped without clear");
   a_scl_half_width: assert property (
      O_BUSY && seen_ff && O_SCL != scl_ff |-> cnt_ff == half)
      else $error("clock half period wrong");
   a_busy_needs_write: assert property (
      $rose(O_BUSY) |-> $past(I_DATA_WR_STB) && O_ENABLE)
      else $error("transfer began without enabled write");
   c_nack_seen: cover property (O_ERR_STATUS[ERR_NACK_BIT]);
   c_overflow_seen: cover property (O_ERR_STATUS[ERR_OVF_BIT]);
   c_full_read: cover property (O_BUFFER_FULL && I_DATA_RD_STB);
endmodule : sie_iic_chan_asserts

// ==== bench/sie_slave_model.sv ====
// Behavioural two-wire slave: acks on demand, sends a byte when read.
// Assumes i_sda is the resolved wire with a pull-up.
`timescale 1ns/1ps
module sie_slave_model (
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_ack,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_tx,
   output logic            o_pull,
   output logic [7:0]      o_rx
);
   int bit_idx = 9;
   initial o_pull = 1'b0;
   initial o_rx = 8'h00;
   always @(negedge i_sda) begin
      if (i_scl) begin
         bit_idx = -1;
      end
   end
   // Zero hold time: lets go right on the fall, as real parts may
   always @(negedge i_scl) begin
      bit_idx = bit_idx + 1;
      o_pull = (bit_idx == 8) ? (i_ack && !i_rd) : (i_rd && bit_idx < 8 && !i_tx[7-bit_idx]);
   end
   always @(posedge i_scl) begin
      if (bit_idx >= 0 && bit_idx < 8) begin
         o_rx = {o_rx[6:0], i_sda};
      end
   end
endmodule : sie_slave_model

// ==== bench/sie_iic_chan_bench.sv ====
// Bench for the two-wire channel: start/stop, errors, receive buffer.
// Assumes the slave model on the wire and small prescaler exponents.
`timescale 1ns/1ps
module sie_iic_chan_bench;
   import sie_pkg::*;
   logic             clk, rst_n, choice, start, stop, wr_stb, rd_stb, rd_mode, send_stop;
   logic             clr_stb, ack, pull, scl, sda_out, oe_n, ena, busy, full;
   logic [PRS_W-1:0] prs0, prs1;
   logic [15:0]      wr_data;
   logic [ERR_W-1:0] clr, err;
   logic [7:0]       rx, tx, slave_rx;
   wire              sda = (oe_n | sda_out) & !pull;
   int               err_total, tests_run, cycles;
   sie_iic_chan uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PRS0(prs0), .I_PRS1(prs1),
      .I_PRS_CHOICE(choice), .I_START(start), .I_STOP(stop), .I_DATA_WR(wr_data),
      .I_DATA_WR_STB(wr_stb), .I_DATA_RD_STB(rd_stb), .I_READ_MODE(rd_mode),
      .I_SEND_STOP(send_stop), .I_FLAG_CLR(clr), .I_FLAG_CLR_STB(clr_stb), .I_SDA_IN(sda),
      .O_SCL(scl), .O_SDA_OUT(sda_out), .O_SDA_OE_N(oe_n), .O_ENABLE(ena), .O_BUSY(busy),
      .O_BUFFER_FULL(full), .O_ERR_STATUS(err), .O_RX_DATA(rx));
   sie_slave_model u_slave (.i_scl(scl), .i_sda(sda), .i_ack(ack), .i_rd(rd_mode),
      .i_tx(tx), .o_pull(pull), .o_rx(slave_rx));
   // ======
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse
   task automatic xfer(input logic [6:0] div, input logic [7:0] d, input logic rd,
                       input logic ak);
      wr_data = {div, 1'b0, d};
      rd_mode = rd;
      ack = ak;
      pulse(wr_stb);
      for (int i = 0; i < 3000 && (busy || i < 2); i++) tick(1);
      chk({7'h00, busy}, 8'h00);
   endtask : xfer
   task automatic clear(input logic [1:0] v);
      clr = v;
      pulse(clr_stb);
      tick(1);
   endtask : clear
   task automatic summarize;
      $display("mismatches=%0d comparisons=%0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   // ======
   // Clock, timeout, sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      {choice, start, stop, wr_stb, rd_stb, rd_mode, clr_stb, ack, rst_n} = 9'h000;
      send_stop = 1'b1; // Stop after every byte, also after a nack
      prs0 = 4'h0;
      prs1 = 4'h1;
      wr_data = 16'h0000;
      clr = 2'b00;
      tx = 8'h3C;
      tick(20);
      rst_n = 1'b1;
      chk({1'b0, ena, busy, full, scl, oe_n, err}, 8'h0C);
      xfer(7'h02, 8'hA5, 1'b0, 1'b1);
      chk(slave_rx, 8'h00);
      pulse(start);
      chk({7'h00, ena}, 8'h01);
      xfer(7'h02, 8'hA5, 1'b0, 1'b1);
      chk(slave_rx, 8'hA5);
      chk({6'h00, err}, 8'h00);
      xfer(7'h03, 8'h5A, 1'b0, 1'b0);
      chk({6'h00, err}, 8'h02);
      clear(err);
      chk({6'h00, err}, 8'h00);
      // Stop before switching the clock source
      pulse(stop);
      chk({7'h00, ena}, 8'h00);
      choice = 1'b1;
      pulse(start);
      xfer(7'h01, 8'hFF, 1'b1, 1'b1);
      chk(rx, tx);
      chk({7'h00, full}, 8'h01);
      xfer(7'h01, 8'hFF, 1'b1, 1'b1);
      chk({6'h00, err}, 8'h01);
      xfer(7'h01, 8'h0F, 1'b0, 1'b0);
      chk({6'h00, err}, 8'h03);
      clear(2'b10);
      chk({6'h00, err}, 8'h01);
      clear(err);
      chk({6'h00, err}, 8'h00);
      pulse(rd_stb);
      chk({7'h00, full}, 8'h00);
      xfer(7'h01, 8'hFF, 1'b1, 1'b1);
      chk({6'h00, err}, 8'h00);
      // Byte kept without stop, then a repeated start from the held bus
      pulse(stop);
      prs0 = 4'h1;
      choice = 1'b0;
      send_stop = 1'b0;
      pulse(start);
      xfer(7'h01, 8'hC3, 1'b0, 1'b1);
      chk({6'h00, scl, oe_n}, 8'h01);
      chk(slave_rx, 8'hC3);
      send_stop = 1'b1;
      xfer(7'h01, 8'h96, 1'b0, 1'b1);
      chk(slave_rx, 8'h96);
      wr_data = 16'h0A55;
      rd_mode = 1'b0;
      pulse(wr_stb);
      tick(20);
      start = 1'b1;
      pulse(stop);
      start = 1'b0;
      chk({4'h0, ena, busy, scl, oe_n}, 8'h03);
      summarize();
   end
endmodule : sie_iic_chan_bench
bind sie_iic_chan sie_iic_chan_asserts u_chk (.*);
